// File: rtl/twdt_defs.svh
/*
 * Offsets, field positions, reset values and counts of the two-stage
 * watchdog. Assumes inclusion by bare name from any design file.
 */
`ifndef TWDT_DEFS_SVH
`define TWDT_DEFS_SVH

// Register indices as printed; byte address is four times the index
`define TWDT_IDX_CLEAR_KEY 16'hF00E
`define TWDT_IDX_PERIOD_MODE 16'hF00F
`define TWDT_ADDR_W 20

// Reset values
`define TWDT_CLEAR_KEY_RST 8'h00
`define TWDT_PERIOD_MODE_RST 8'h82

// Field positions in the mode register
`define TWDT_HALT_EN_BIT 7
`define TWDT_SEL_MSB 1
`define TWDT_SEL_LSB 0

// Clear keys
`define TWDT_KEY_FIRST 8'h5A
`define TWDT_KEY_SECOND 8'hA5

// Low-speed clock cycles per divided tick
`define TWDT_PRESCALE 128

// Overflow periods in low-speed clock cycles, per period select
`define TWDT_OVF_SEL0 4096
`define TWDT_OVF_SEL1 16384
`define TWDT_OVF_SEL2 65536
`define TWDT_OVF_SEL3 262144

`endif

// File: rtl/twdt_pkg.sv
/*
 * Types of the two-stage watchdog. Assumes nothing of its surroundings.
 */
package twdt_pkg;

    // Warning state, Gray coded along armed, init, warned, fired
    typedef enum logic [1:0] {
        st_armed = 2'b00,
        st_init = 2'b01,
        st_warned = 2'b11,
        st_fired = 2'b10
    } twdt_state_t;

    // Power state as seen from the power controller
    typedef struct packed {
        logic stop_mode;
        logic deepest_halt_state;
    } twdt_power_t;

    // Mode register layout; bits 6:2 are not stored
    typedef struct packed {
        logic halt_count_en;
        logic [4:0] unused;
        logic [1:0] period_select;
    } twdt_mode_t;

    // Events toward the interrupt and reset controllers
    typedef struct packed {
        logic watchdog_interrupt;
        logic halt_wake;
        logic watchdog_reset;
    } twdt_event_t;

endpackage

// File: rtl/twdt_sync.sv
/*
 * Two flip-flop synchroniser for asynchronous levels.
 * Assumes the input is a level from outside the pclk domain.
 */
`timescale 1ns/1ps
`default_nettype none

module twdt_sync #(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Level in and synchronised level out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// File: rtl/twdt_top.sv
/*
 * Two-stage watchdog timer with an APB register slave.
 * Assumes a 25 MHz pclk, a free low-speed clock pin far slower than
 * pclk, and power-state levels driven from logic on pclk.
 */
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

`include "twdt_defs.svh"

////////////////////////////////////////////////////////////////////////
module twdt_top
    import twdt_pkg::*;
(
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`TWDT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Low-speed clock pin and power state
    input wire logic low_speed_clock,
    input wire twdt_power_t power_state,
    // Events toward interrupt and reset controllers
    output twdt_event_t wdt_events,
    // Pointer state for observation
    output logic sequence_pointer
);

    // The slow pin is only sampled on pclk, so each of its half periods
    // must span several pclk cycles; a faster pin would drop edges and
    // quietly stretch every watchdog period
    localparam int PRE_W = $clog2(`TWDT_PRESCALE);
    localparam int CNT_W = $clog2(`TWDT_OVF_SEL3 / `TWDT_PRESCALE);
    localparam logic [`TWDT_ADDR_W-1:0] ADDR_KEY =
        `TWDT_ADDR_W'(`TWDT_IDX_CLEAR_KEY * 4);
    localparam logic [`TWDT_ADDR_W-1:0] ADDR_MODE =
        `TWDT_ADDR_W'(`TWDT_IDX_PERIOD_MODE * 4);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(`TWDT_PRESCALE - 1);

    // Last tick index before overflow for a period select
    function automatic logic [CNT_W-1:0] last_tick(input logic [1:0] sel);
        logic [CNT_W-1:0] r;
        r = '0;
        unique case (sel)
            2'b00: r = CNT_W'(`TWDT_OVF_SEL0 / `TWDT_PRESCALE - 1);
            2'b01: r = CNT_W'(`TWDT_OVF_SEL1 / `TWDT_PRESCALE - 1);
            2'b10: r = CNT_W'(`TWDT_OVF_SEL2 / `TWDT_PRESCALE - 1);
            2'b11: r = CNT_W'(`TWDT_OVF_SEL3 / `TWDT_PRESCALE - 1);
        endcase
        return r;
    endfunction

    logic slow_sync;
    logic slow_last_reg;
    logic ls_rise;
    logic ls_fall;
    logic [PRE_W-1:0] pre_reg;
    logic tick;
    logic [CNT_W-1:0] count_reg;
    logic run;
    logic overflow;
    twdt_state_t state_reg;
    twdt_state_t state_next;
    twdt_mode_t mode_reg;
    logic pointer_reg;
    logic key_armed_reg;
    logic wr_access;
    logic rd_access;
    logic mapped;
    logic key_write;
    logic clear_hit;
    logic [7:0] wbyte;
    logic mode_write;
    logic init_phase;

    ////////////////////////////////////////////////////////////////////
    // Low-speed clock: synchronise, then find edges on the second stage
    twdt_sync #(
        .WIDTH(1)
    ) u_ls_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(low_speed_clock),
        .sync_out(slow_sync)
    );

    // Delayed copy of the synchronised level; its reset value matches
    // the synchroniser's, so no false edge follows reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            slow_last_reg <= 1'b0;
        else
            slow_last_reg <= slow_sync;
    end

    // One-cycle strobes on each synchronised slow edge
    assign ls_rise = slow_sync & ~slow_last_reg;
    assign ls_fall = ~slow_sync & slow_last_reg;

    // Counting runs unless stopped, or halted with the halt enable low.
    // The fired state stops counting; only presetn leaves it.
    assign run = ~power_state.stop_mode
        & ~(power_state.deepest_halt_state & ~mode_reg.halt_count_en)
        & (state_reg != st_fired);

    ////////////////////////////////////////////////////////////////////
    // Prescaler: counts only while running, never cleared by a key, so the clear
    // window is up to one tick shorter than the overflow period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pre_reg <= '0;
        else if (run && ls_rise)
            pre_reg <= pre_reg + PRE_W'(1);
    end

    // One tick per 128 synchronised rises while running
    assign tick = run & ls_rise & (pre_reg == PRE_LAST);

    ////////////////////////////////////////////////////////////////////
    // APB decode: zero wait states, error on unmapped addresses
    assign mapped = (paddr == ADDR_KEY) || (paddr == ADDR_MODE);
    assign wr_access = psel & penable & pwrite & mapped;
    assign rd_access = psel & ~pwrite & mapped;
    assign wbyte = pwdata[7:0];
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Init phase right after a first overflow; counter and pointer are
    // held and key writes are lost, which software must detect itself
    assign init_phase = (state_reg == st_init);

    // Only byte lane 0 carries register data; a write without it is
    // dropped rather than half applied
    assign key_write = wr_access & (paddr == ADDR_KEY) & pstrb[0]
        & ~init_phase;
    assign mode_write = wr_access & (paddr == ADDR_MODE) & pstrb[0];

    // A completed key pair clears the counter
    assign clear_hit = key_write & pointer_reg & key_armed_reg
        & (wbyte == `TWDT_KEY_SECOND);

    // Overflow at or past the end, so a period cut short by a mode write
    // still ends at the next tick instead of wrapping round
    assign overflow = tick & (count_reg >= last_tick(mode_reg.period_select));

    ////////////////////////////////////////////////////////////////////
    // Watchdog counter; held at zero during init, no disable exists.
    // Overflow and clear in one cycle both zero it; the state decides.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_reg <= '0;
        else if (init_phase)
            count_reg <= '0;
        else if (overflow)
            count_reg <= '0;
        else if (clear_hit)
            count_reg <= '0;
        else if (tick)
            count_reg <= count_reg + CNT_W'(1);
    end

    ////////////////////////////////////////////////////////////////////
    // Sequence pointer and first-key memory; overflow outranks a write,
    // so the pointer always reads 0 just after any overflow
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pointer_reg <= 1'b0;
            key_armed_reg <= 1'b0;
        end
        else if (overflow || init_phase)
        begin
            pointer_reg <= 1'b0;
            key_armed_reg <= 1'b0;
        end
        else if (key_write)
        begin
            pointer_reg <= ~pointer_reg;
            key_armed_reg <= ~pointer_reg
                & (wbyte == `TWDT_KEY_FIRST);
        end
    end

    assign sequence_pointer = pointer_reg;

    ////////////////////////////////////////////////////////////////////
    // Mode register; reserved bits are not stored and read as zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_reg <= twdt_mode_t'(`TWDT_PERIOD_MODE_RST);
        else if (mode_write)
        begin
            mode_reg.halt_count_en <= wbyte[`TWDT_HALT_EN_BIT];
            mode_reg.unused <= '0;
            mode_reg.period_select <=
                wbyte[`TWDT_SEL_MSB:`TWDT_SEL_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Warning state: the init phase ends on the next falling slow edge,
    // which is half a low-speed period after the overflowing rise.
    // A clear in the armed state only zeroes the counter; the fired
    // state is left only by a system reset.
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            st_armed:
                if (overflow)
                    state_next = st_init;
            st_init:
                if (ls_fall)
                    state_next = st_warned;
            st_warned:
                if (overflow)
                    state_next = st_fired;
                else if (clear_hit)
                    state_next = st_armed;
            st_fired:
                state_next = st_fired;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= st_armed;
        else
            state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////////
    // Event outputs: interrupt and wake pulse once, reset holds
    // until the system reset comes back through presetn.
    // Wake is kept apart from the interrupt so the power controller
    // need not decode the interrupt controller's request.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wdt_events <= '0;
        else
        begin
            wdt_events.watchdog_interrupt <=
                overflow & (state_reg == st_armed);
            wdt_events.halt_wake <=
                overflow & (state_reg == st_armed);
            wdt_events.watchdog_reset <= wdt_events.watchdog_reset
                | (overflow & (state_reg == st_warned));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data registered in a read's setup phase, held through any mapped access, zero otherwise;
    // unmapped reads return zero even right after a mapped read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (rd_access && !penable)
        begin
            if (paddr == ADDR_KEY)
                prdata <= {31'h0, pointer_reg};
            else
                prdata <= {24'h0, mode_reg.halt_count_en, 5'h00,
                    mode_reg.period_select};
        end
        else if (!psel || !mapped)
            prdata <= '0;
    end

endmodule

`default_nettype wire

// File: dv/twdt_top_monitor.sv
/*
 * Port checker of the two-stage watchdog.
 * Assumes binding to twdt_top; all signals but low_speed_clock in the pclk domain.
 */
`timescale 1ns/1ps
`default_nettype none

`include "twdt_defs.svh"

module twdt_top_monitor
    import twdt_pkg::*;
(
    // Clock, reset and APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`TWDT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Slow clock, power state and outputs
    input wire logic low_speed_clock,
    input wire twdt_power_t power_state,
    input wire twdt_event_t wdt_events,
    input wire logic sequence_pointer
);
    localparam logic [19:0] KEY_A = 20'(`TWDT_IDX_CLEAR_KEY * 4);
    localparam logic [19:0] MODE_A = 20'(`TWDT_IDX_PERIOD_MODE * 4);
    logic [6:0] quiet_reg;
    logic key_wr;
    logic acc;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Cycles since an interrupt; init may swallow writes just after one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            quiet_reg <= 7'h7F;
        else if (wdt_events.watchdog_interrupt)
            quiet_reg <= 7'h00;
        else if (quiet_reg != 7'h7F)
            quiet_reg <= quiet_reg + 7'h01;
    end

    // Access phase and key writes that must be taken
    assign acc = psel && penable;
    assign key_wr = acc && pwrite && pstrb[0] && paddr == KEY_A
        && quiet_reg == 7'h7F;

    ////////////////////////////////////////////////////////////////////
    property p_toggle;
        key_wr |=> sequence_pointer != $past(sequence_pointer);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("pointer did not invert on key write");
    property p_read;
        acc && !pwrite && paddr == KEY_A
            |-> prdata == {31'h0, sequence_pointer};
    endproperty
    a_read: assert property (p_read)
        else $error("key read differs from pointer");
    property p_ovf_ptr;
        wdt_events.watchdog_interrupt |-> !sequence_pointer;
    endproperty
    a_ovf_ptr: assert property (p_ovf_ptr)
        else $error("pointer not zero at overflow");
    property p_init;
        wdt_events.watchdog_interrupt |=> !sequence_pointer [*2];
    endproperty
    a_init: assert property (p_init)
        else $error("pointer moved during init");
    property p_wake;
        wdt_events.watchdog_interrupt == wdt_events.halt_wake;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake differs from interrupt");
    property p_sticky;
        wdt_events.watchdog_reset |=> wdt_events.watchdog_reset;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("watchdog reset dropped");
    property p_no_int;
        $rose(wdt_events.watchdog_reset) |-> !wdt_events.watchdog_interrupt;
    endproperty
    a_no_int: assert property (p_no_int)
        else $error("interrupt with second overflow");
    property p_unmapped;
        acc && paddr != KEY_A && paddr != MODE_A
            |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
endmodule

bind twdt_top twdt_top_monitor u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_speed_clock(low_speed_clock),
    .power_state(power_state), .wdt_events(wdt_events),
    .sequence_pointer(sequence_pointer));

`default_nettype wire

// File: dv/twdt_top_tb_top.sv
/*
 * Self-checking bench of the two-stage watchdog.
 * Assumes twdt_top and its checker; slow clock runs at pclk / 8.
 */
`timescale 1ns/1ps
`default_nettype none

`include "twdt_defs.svh"

module twdt_top_tb_top
    import twdt_pkg::*;
;
    localparam logic [19:0] KEY_A = 20'(`TWDT_IDX_CLEAR_KEY * 4);
    localparam logic [19:0] MODE_A = 20'(`TWDT_IDX_PERIOD_MODE * 4);
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [19:0] paddr = 20'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic low_speed_clock = 1'b0;
    logic sequence_pointer;
    twdt_power_t power_state = 2'h0;
    twdt_event_t wdt_events;
    logic [1:0] div = 2'h0;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int rises = 0;
    int r0;

    twdt_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .low_speed_clock(low_speed_clock), .power_state(power_state),
        .wdt_events(wdt_events), .sequence_pointer(sequence_pointer));

    ////////////////////////////////////////////////////////////////////
    // Bus clock
    initial
    begin
        forever #20 pclk = ~pclk;
    end

    // Slow clock at pclk / 8, fast to keep two overflows short
    always @(posedge pclk)
    begin
        div <= div + 2'h1;
        if (div == 2'h3)
            low_speed_clock <= ~low_speed_clock;
    end

    // Slow rises seen, and a hang limit
    always @(posedge low_speed_clock) rises++;
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            fail_count++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task check(string name, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task finish_test;
        if (fail_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One APB byte transfer; result lands in rd and err
    task apb(input logic wr, input logic [19:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= 4'h1;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Waits for the interrupt (0) or the watchdog reset (1)
    task wait_evt(input logic which);
        do
        begin
            @(posedge pclk);
            #1;
        end
        while ((which ? wdt_events.watchdog_reset
            : wdt_events.watchdog_interrupt) !== 1'b1);
    endtask

    // Holds a power state over n slow rises, switched mid low phase
    task hold_power(input logic st, input logic dh, input int n);
        do @(posedge pclk); while (low_speed_clock !== 1'b0 || div != 2'h1);
        power_state.stop_mode <= st;
        power_state.deepest_halt_state <= dh;
        repeat (n) @(posedge low_speed_clock);
        do @(posedge pclk); while (low_speed_clock !== 1'b0 || div != 2'h1);
        power_state <= 2'h0;
    endtask

    ////////////////////////////////////////////////////////////////////
    task t_regs;
        apb(1'b0, KEY_A, 8'h00);
        check("key reset", rd, {24'h0, `TWDT_CLEAR_KEY_RST});
        apb(1'b0, MODE_A, 8'h00);
        check("mode reset", rd, {24'h0, `TWDT_PERIOD_MODE_RST});
        apb(1'b0, 20'h00100, 8'h00);
        check("unmapped err", {31'h0, err}, 32'h1);
    endtask

    task t_pointer;
        apb(1'b1, MODE_A, 8'hFF);
        apb(1'b0, MODE_A, 8'h00);
        check("mode bits", rd, 32'h83);
        apb(1'b1, MODE_A, 8'h80);
        apb(1'b0, MODE_A, 8'h00);
        check("mode", rd, 32'h80);
        apb(1'b1, KEY_A, 8'h11);
        apb(1'b0, KEY_A, 8'h00);
        check("ptr any", rd, 32'h1);
        apb(1'b1, KEY_A, `TWDT_KEY_FIRST);
        apb(1'b0, KEY_A, 8'h00);
        check("ptr late key", rd, 32'h0);
        apb(1'b1, KEY_A, `TWDT_KEY_SECOND);
        apb(1'b0, KEY_A, 8'h00);
        check("ptr early key", rd, 32'h1);
        // Let the count advance so that a lost clear shortens the window
        repeat (512) @(posedge low_speed_clock);
        apb(1'b1, KEY_A, 8'h00);
        apb(1'b1, KEY_A, `TWDT_KEY_FIRST);
        apb(1'b1, KEY_A, `TWDT_KEY_SECOND);
        r0 = rises;
        apb(1'b0, KEY_A, 8'h00);
        check("ptr clear", rd, 32'h0);
    endtask

    // Overflow after a clear comes within the window, as an interrupt
    task t_first;
        wait_evt(1'b0);
        check("wake", wdt_events.halt_wake, 1'b1);
        check("no reset", wdt_events.watchdog_reset, 1'b0);
        check("ptr ovf", sequence_pointer, 1'b0);
        check("window", (rises - r0 >= `TWDT_OVF_SEL0 - `TWDT_PRESCALE)
            && (rises - r0 <= `TWDT_OVF_SEL0), 1'b1);
        r0 = rises;
        // Handler on the fast clock: its first write falls in init
        apb(1'b1, KEY_A, 8'h11);
        apb(1'b0, KEY_A, 8'h00);
        check("init write", rd, 32'h0);
        do
        begin
            apb(1'b1, KEY_A, 8'h11);
            apb(1'b0, KEY_A, 8'h00);
        end
        while (rd !== 32'h1);
        apb(1'b1, KEY_A, 8'h11);
        apb(1'b0, KEY_A, 8'h00);
        check("ptr handler", rd, 32'h0);
    endtask

    // Stop and halt pauses stretch the second period exactly
    task t_second;
        hold_power(1'b1, 1'b0, 50);
        apb(1'b1, MODE_A, 8'h00);
        hold_power(1'b0, 1'b1, 50);
        apb(1'b1, MODE_A, 8'h80);
        hold_power(1'b0, 1'b1, 20);
        wait_evt(1'b1);
        check("period", rises - r0, `TWDT_OVF_SEL0 + 100);
        check("no int", wdt_events.watchdog_interrupt, 1'b0);
    endtask

    task t_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, MODE_A, 8'h00);
        check("mode again", rd, {24'h0, `TWDT_PERIOD_MODE_RST});
        check("events", wdt_events, 3'h0);
    endtask

    // Main sequence
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_pointer();
        t_first();
        t_second();
        t_reset();
        finish_test();
    end
endmodule

`default_nettype wire
